// ==== design/ssrc_regs.vh ====
// Register offsets, field positions and reset values of the sleep/rate configuration bank
`ifndef SSRC_REGS_VH
`define SSRC_REGS_VH
`define SSRC_ADDR_W 7
`define SSRC_DATA_W 16
`define SSRC_OFS_SLEEP 7'h03
`define SSRC_OFS_CLEAR 7'h04
`define SSRC_OFS_OUTCFG 7'h05
`define SSRC_OFS_RATE 7'h06
`define SSRC_SLEEP_AUTO_BIT 0
`define SSRC_SLEEP_MANUAL_BIT 1
`define SSRC_CLEAR_REQ_BIT 0
`define SSRC_OUT_SLEEP_MUTE_BIT 3
`define SSRC_OUT_COAX_MUTE_BIT 4
`define SSRC_RATE_AUTO_BIT 0
`define SSRC_RATE_MAN_LSB 1
`define SSRC_RATE_MAN_MSB 4
`define SSRC_RATE_AUDIO_BIT 8
`define SSRC_RATE_EN_LSB 9
`define SSRC_RATE_EN_MSB 13
`define SSRC_RST_SLEEP 16'h0001
`define SSRC_RST_CLEAR 16'h0000
`define SSRC_RST_OUTCFG 16'h0001
`define SSRC_RST_RATE 16'h3e01
`define SSRC_OUT_ON 2'h0
`define SSRC_OUT_MUTE 2'h1
`define SSRC_OUT_OFF 2'h2
`endif

// ==== design/ssrc_reg16.v ====
// One 16-bit host register with reset value and write enable
`timescale 1ns/1ps
module ssrc_reg16
#(
    parameter [15:0] RESET_VALUE = 16'h0000
)
(
    input wire mclk,
    input wire rst_n,
    input wire wr_en,
    input wire [15:0] wr_data,
    output reg [15:0] value
);
    // Reserved bits are stored as written so read-modify-write round trips
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            value <= RESET_VALUE;
        else if (wr_en)
            value <= wr_data;
    end
endmodule // ssrc_reg16

// ==== design/ssrc_config_regs.v ====
// Sleep, counter clear, output behaviour and rate detection control registers
`timescale 1ns/1ps
`include "ssrc_regs.vh"

// Summary of operation
// - With auto sleep off, manual sleep bit 1 forces awake (0) or asleep (1).
// - Auto sleep bit 0 resets to 1; when set, sleep follows loss of signal.
// - Clear bit 0 does nothing; 1 requests clearing of sticky counters.
// - Coax-drive mode, no loopback: bit 4 selects power-down (0) or mute (1).
// - During sleep bit 3 selects trace output power-down (0) or mute (1).
// - Per-rate autodetect enables in bits 13..9 reset to 1, trace input only.
// - Audio-rate autodetect enable bit 8 resets to 0, trace input only.
// - Manual rate field bits 4:1 codes 0..6; code 7 reserved.
// - Recovery locks to manual rate only while autodetect is disabled.
// - Autodetect enable bit 0 resets to 1; cleared means manual rate used.
module ssrc_config_regs
(
    input wire mclk,
    input wire rst_n,
    input wire host_wr,
    input wire host_rd,
    input wire [`SSRC_ADDR_W-1:0] host_addr,
    input wire [`SSRC_DATA_W-1:0] host_wdata,
    output reg [`SSRC_DATA_W-1:0] host_rdata,
    output reg host_rvalid,
    input wire loss_of_signal,
    input wire coax_drive_mode,
    input wire loopback_en,
    input wire counters_cleared,
    output reg sleep,
    output reg clear_counts,
    output reg clear_counts_status,
    output reg [1:0] trace_driver_output_mode,
    output reg rate_autodetect_en,
    output reg [3:0] cdr_manual_rate,
    output reg cdr_manual_lock,
    output reg [5:0] trace_equalizer_input_rate_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by write strobes and read mux
    function is_ofs;
        input [`SSRC_ADDR_W-1:0] a;
        input [`SSRC_ADDR_W-1:0] ofs;
        begin
            is_ofs = (a == ofs);
        end
    endfunction

    // Output choice shared by the sleep and coax-drive cases
    function [1:0] mute_or_off;
        input mute;
        begin
            if (mute)
                mute_or_off = `SSRC_OUT_MUTE;
            else
                mute_or_off = `SSRC_OUT_OFF;
        end
    endfunction

    wire [15:0] sleep_control;
    wire [15:0] counter_clear_control;
    wire [15:0] output_behaviour_config;
    wire [15:0] rate_detection_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Write strobes; an unmapped offset enables none, so such a write is dropped
    wire wr_sleep = host_wr && is_ofs(host_addr, `SSRC_OFS_SLEEP);
    wire wr_clear = host_wr && is_ofs(host_addr, `SSRC_OFS_CLEAR);
    wire wr_outcfg = host_wr && is_ofs(host_addr, `SSRC_OFS_OUTCFG);
    wire wr_rate = host_wr && is_ofs(host_addr, `SSRC_OFS_RATE);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    // Reserved bits are kept as written so read-modify-write leaves them intact
    ssrc_reg16 #(.RESET_VALUE(`SSRC_RST_SLEEP)) u_sleep
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_sleep),
        .wr_data(host_wdata),
        .value(sleep_control)
    );

    ssrc_reg16 #(.RESET_VALUE(`SSRC_RST_CLEAR)) u_clear
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_clear),
        .wr_data(host_wdata),
        .value(counter_clear_control)
    );

    ssrc_reg16 #(.RESET_VALUE(`SSRC_RST_OUTCFG)) u_outcfg
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_outcfg),
        .wr_data(host_wdata),
        .value(output_behaviour_config)
    );

    ssrc_reg16 #(.RESET_VALUE(`SSRC_RST_RATE)) u_rate
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_rate),
        .wr_data(host_wdata),
        .value(rate_detection_mode)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Field extraction
    // Sleep control fields
    wire auto_sleep = sleep_control[`SSRC_SLEEP_AUTO_BIT];
    wire manual_sleep = sleep_control[`SSRC_SLEEP_MANUAL_BIT];
    // Handshake request, copied straight to the counter logic
    wire clear_req = counter_clear_control[`SSRC_CLEAR_REQ_BIT];
    // Trace output behaviour fields; reserved bits 2:0 are stored but unused
    wire mute_in_sleep = output_behaviour_config[`SSRC_OUT_SLEEP_MUTE_BIT];
    wire mute_in_coax = output_behaviour_config[`SSRC_OUT_COAX_MUTE_BIT];
    // Coax-drive rule applies only while loopback is off
    wire coax_rule = coax_drive_mode && !loopback_en;
    // Rate detection fields; reserved code 7 is not filtered, the host must avoid it
    wire auto_rate = rate_detection_mode[`SSRC_RATE_AUTO_BIT];
    wire [3:0] manual_rate = rate_detection_mode[`SSRC_RATE_MAN_MSB:`SSRC_RATE_MAN_LSB];
    // Per-rate enables, highest rate first, audio rate last
    wire [5:0] rate_en_field = {rate_detection_mode[`SSRC_RATE_EN_MSB:`SSRC_RATE_EN_LSB],
        rate_detection_mode[`SSRC_RATE_AUDIO_BIT]};

    // Sleep decision: auto follows loss of signal, else the manual bit
    // Loss of signal is taken as synchronous to mclk, so no extra stage is spent
    wire next_sleep = auto_sleep ? loss_of_signal : manual_sleep;

    // Sleep wins over coax-drive since the link is idle either way
    reg [1:0] next_out_mode;
    always @*
    begin
        next_out_mode = `SSRC_OUT_ON;
        if (next_sleep)
            next_out_mode = mute_or_off(mute_in_sleep);
        else if (coax_rule)
            next_out_mode = mute_or_off(mute_in_coax);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered control outputs
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Awake with autodetect on until the first edge loads the stored fields
            sleep <= 1'b0;
            trace_driver_output_mode <= `SSRC_OUT_ON;
            rate_autodetect_en <= 1'b1;
            cdr_manual_rate <= 4'h0;
            cdr_manual_lock <= 1'b0;
            trace_equalizer_input_rate_en <= 6'h3e;
        end
        else
        begin
            sleep <= next_sleep;
            trace_driver_output_mode <= next_out_mode;
            rate_autodetect_en <= auto_rate;
            // Manual rate only steers the recovery when autodetect is off
            cdr_manual_lock <= !auto_rate;
            // Reserved code 7 is passed as stored; host must not write it
            cdr_manual_rate <= manual_rate;
            trace_equalizer_input_rate_en <= rate_en_field;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Four-phase clear handshake: status rises once counters report cleared,
    // and drops only after the request is withdrawn. A withdrawal wins over a
    // late cleared report in the same cycle, so no stale acknowledge is left
    // standing after the host has already moved on
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clear_counts <= 1'b0;
            clear_counts_status <= 1'b0;
        end
        else
        begin
            clear_counts <= clear_req;
            if (!clear_req)
                clear_counts_status <= 1'b0;
            else if (clear_counts && counters_cleared)
                clear_counts_status <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: one cycle latency, unmapped offsets read zero
    // Read data hold between reads so a slow host may sample them late
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rdata <= 16'h0000;
            host_rvalid <= 1'b0;
        end
        else
        begin
            host_rvalid <= host_rd;
            if (!host_rd)
                host_rdata <= host_rdata;
            else if (is_ofs(host_addr, `SSRC_OFS_SLEEP))
                host_rdata <= sleep_control;
            else if (is_ofs(host_addr, `SSRC_OFS_CLEAR))
                host_rdata <= counter_clear_control;
            else if (is_ofs(host_addr, `SSRC_OFS_OUTCFG))
                host_rdata <= output_behaviour_config;
            else if (is_ofs(host_addr, `SSRC_OFS_RATE))
                host_rdata <= rate_detection_mode;
            else
                host_rdata <= 16'h0000;
        end
    end

endmodule // ssrc_config_regs

// ==== verif/ssrc_config_asserts.sv ====
// Port checker of the sleep/rate configuration bank
`timescale 1ns/1ps
module ssrc_config_asserts
(
    input wire mclk,
    input wire rst_n,
    input wire host_wr,
    input wire host_rd,
    input wire [6:0] host_addr,
    input wire [15:0] host_wdata,
    input wire [15:0] host_rdata,
    input wire host_rvalid,
    input wire loss_of_signal,
    input wire coax_drive_mode,
    input wire loopback_en,
    input wire counters_cleared,
    input wire sleep,
    input wire clear_counts,
    input wire clear_counts_status,
    input wire [1:0] trace_driver_output_mode,
    input wire rate_autodetect_en,
    input wire [3:0] cdr_manual_rate,
    input wire cdr_manual_lock,
    input wire [5:0] trace_equalizer_input_rate_en
);
reg [15:0] s3, s4, s5, s6;
wire s_now = s3[0] ? loss_of_signal : s3[1];
wire [1:0] m_now = s_now ? (s5[3] ? 2'h1 : 2'h2) : (coax_drive_mode && !loopback_en) ? (s5[4] ? 2'h1 : 2'h2) : 2'h0;
wire [15:0] rd_now = host_addr == 7'h03 ? s3 : host_addr == 7'h04 ? s4 : host_addr == 7'h05 ? s5 :
    host_addr == 7'h06 ? s6 : 16'h0000;
// Shadow registers, so every output can be tied to what the host wrote
always @(posedge mclk or negedge rst_n)
begin
    if (!rst_n)
    begin
        s3 <= 16'h0001;
        s4 <= 16'h0000;
        s5 <= 16'h0001;
        s6 <= 16'h3e01;
    end
    else if (host_wr)
    begin
        if (host_addr == 7'h03) s3 <= host_wdata;
        if (host_addr == 7'h04) s4 <= host_wdata;
        if (host_addr == 7'h05) s5 <= host_wdata;
        if (host_addr == 7'h06) s6 <= host_wdata;
    end
end
////////////////////////////////////////
default clocking dc @(posedge mclk); endclocking
default disable iff (!rst_n);
// Request still held and counters already zero
sequence req_met;
    clear_counts && counters_cleared && s4[0];
endsequence
sleep_follow_a:
    assert property ($past(rst_n) |-> sleep == $past(s_now)) else $error("sleep level wrong");
clear_copy_a:
    assert property ($past(rst_n) |-> clear_counts == $past(s4[0])) else $error("clear request wrong");
status_rise_a:
    assert property (req_met |=> clear_counts_status) else $error("clear status late");
status_drop_a:
    assert property (!clear_counts |-> !clear_counts_status) else $error("clear status stuck");
out_mode_a:
    assert property ($past(rst_n) |-> trace_driver_output_mode == $past(m_now)) else $error("output mode wrong");
rate_copy_a:
    assert property ($past(rst_n) |-> {rate_autodetect_en, cdr_manual_rate, trace_equalizer_input_rate_en}
        == $past({s6[0], s6[4:1], s6[13:8]})) else $error("rate fields wrong");
manual_lock_a:
    assert property (cdr_manual_lock != rate_autodetect_en) else $error("manual lock wrong");
read_data_a:
    assert property (host_rd |=> host_rvalid && host_rdata == $past(rd_now)) else $error("read data wrong");
rvalid_cause_a:
    assert property (host_rvalid |-> $past(host_rd)) else $error("stray read valid");
endmodule // ssrc_config_asserts
bind ssrc_config_regs ssrc_config_asserts u_ssrc_config_asserts (.mclk, .rst_n, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata, .host_rvalid, .loss_of_signal, .coax_drive_mode, .loopback_en, .counters_cleared,
    .sleep, .clear_counts, .clear_counts_status, .trace_driver_output_mode, .rate_autodetect_en, .cdr_manual_rate,
    .cdr_manual_lock, .trace_equalizer_input_rate_en);

// ==== verif/sdi_sleep_rate_config_regs_test.sv ====
// Self-checking bench of the sleep/rate configuration bank
`timescale 1ns/1ps
module sdi_sleep_rate_config_regs_test;
reg mclk, rst_n, host_wr, host_rd, loss_of_signal, coax_drive_mode, loopback_en, counters_cleared;
reg [6:0] host_addr;
reg [15:0] host_wdata;
wire [15:0] host_rdata;
wire [3:0] cdr_manual_rate;
wire [5:0] trace_equalizer_input_rate_en;
wire [1:0] trace_driver_output_mode;
wire host_rvalid, sleep, clear_counts, clear_counts_status, rate_autodetect_en, cdr_manual_lock;
// Rate outputs gathered in one word for comparison
wire [10:0] rate_out = {rate_autodetect_en, cdr_manual_rate, trace_equalizer_input_rate_en};
integer bad_count = 0, checks_done = 0, seed = 32'h2eec9141, cyc = 0, i, d;
integer m [3:6];
ssrc_config_regs u_ssrc_config_regs (.mclk, .rst_n, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
    .host_rvalid, .loss_of_signal, .coax_drive_mode, .loopback_en, .counters_cleared, .sleep, .clear_counts,
    .clear_counts_status, .trace_driver_output_mode, .rate_autodetect_en, .cdr_manual_rate, .cdr_manual_lock,
    .trace_equalizer_input_rate_en);
////////////////////////////////////////
task chk(input [127:0] name, input [15:0] exp, input [15:0] got);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
    end
end
endtask
// Write, update the model, then wait until the derived outputs settle
task wr(input [6:0] a, input [15:0] v);
begin
    @(posedge mclk) #1;
    host_wr = 1;
    host_addr = a;
    host_wdata = v;
    @(posedge mclk) #1;
    host_wr = 0;
    if (a >= 3 && a <= 6) m[a] = v;
    @(posedge mclk) #1;
end
endtask
task rd(input [6:0] a);
begin
    @(posedge mclk) #1;
    host_rd = 1;
    host_addr = a;
    @(posedge mclk) #1;
    host_rd = 0;
    chk("rvalid", 1, host_rvalid);
    chk("rdata", (a >= 3 && a <= 6) ? m[a] : 0, host_rdata);
end
endtask
// Sleep takes priority over the cable-driver choice
function [1:0] em(input s);
    em = s ? (m[5][3] ? 1 : 2) : (coax_drive_mode && !loopback_en) ? (m[5][4] ? 1 : 2) : 0;
endfunction
// Model of the register reset values
task model_reset;
begin
    m[3] = 16'h0001;
    m[4] = 0;
    m[5] = 16'h0001;
    m[6] = 16'h3e01;
end
endtask
task summarize;
begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
end
endtask
////////////////////////////////////////
initial
begin
    mclk = 0;
    forever #20 mclk = ~mclk;
end
// Hang guard, well above the roughly 930 cycles the run needs
always @(posedge mclk)
begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
        bad_count = bad_count + 1;
        summarize;
    end
end
initial
begin
    {rst_n, host_wr, host_rd, loss_of_signal, coax_drive_mode, loopback_en, counters_cleared} = 0;
    host_addr = 0;
    host_wdata = 0;
    model_reset;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1;
    for (i = 3; i < 8; i = i + 1)
        rd(i[6:0]);
    // Every sleep mode, loss state, cable mode, loopback and output choice
    for (i = 0; i < 128; i = i + 1)
    begin
        {loopback_en, coax_drive_mode, loss_of_signal} = i[2:0];
        wr(7'h03, {14'h0000, i[4:3]});
        wr(7'h05, {11'h000, i[6:5], 3'h1});
        d = m[3][0] ? i[0] : m[3][1];
        chk("sleep", d, sleep);
        chk("mode", em(d), trace_driver_output_mode);
    end
    wr(7'h04, 16'h0001);
    chk("clear", 1, clear_counts);
    chk("status", 0, clear_counts_status);
    counters_cleared = 1;
    for (d = 0; d < 10 && clear_counts_status !== 1'b1; d = d + 1)
        @(posedge mclk) #1;
    chk("status", 1, clear_counts_status);
    wr(7'h04, 16'h0000);
    chk("status", 0, clear_counts_status);
    counters_cleared = 0;
    // Random enables, cable mode and codes; each word written with autodetect on first, then as drawn
    for (i = 0; i < 20; i = i + 1)
    begin
        d = $random(seed);
        coax_drive_mode = d[0];
        d = $random(seed) & 16'h3f01;
        // Code 0 belongs to the cable equalizer side only, code 7 is reserved
        d[4:1] = coax_drive_mode ? 1 + {$random(seed)} % 6 : {$random(seed)} % 7;
        wr(7'h06, d[15:0] | 16'h0001);
        wr(7'h06, d[15:0]);
        chk("rate", {d[0], d[4:1], d[13:8]}, rate_out);
        chk("lock", !d[0], cdr_manual_lock);
    end
    // Reset in mid-run: registers and derived outputs go back to their reset values
    rst_n = 0;
    model_reset;
    @(posedge mclk) #1;
    chk("sleep", 0, sleep);
    chk("rate", {1'b1, 4'h0, 6'h3e}, rate_out);
    rst_n = 1;
    // Unmapped write of its existing zero value must leave every mapped register alone
    wr(7'h02, 16'h0000);
    for (i = 2; i < 8; i = i + 1)
        rd(i[6:0]);
    summarize;
end
endmodule // sdi_sleep_rate_config_regs_test
